/* File: config_prom_pkg.sv */
// shared constants and state types for the configuration prom readout control
`default_nettype none
package config_prom_pkg;

	// system clock and power-on release timing
	localparam int MCLK_PERIOD_NS = 5;
	localparam int NS_PER_MS = 1000000;
	localparam int OER_RELEASE_MAX_MS = 1;
	// longest time, so the count rounds down
	localparam int OER_RELEASE_CYCLES = (OER_RELEASE_MAX_MS * NS_PER_MS) / MCLK_PERIOD_NS;

	// array geometry and forwarded clock defaults
	localparam int ARRAY_DEPTH_DEF = 1048576;
	localparam int DATA_WIDTH_DEF = 1;
	localparam int REV_COUNT_DEF = 4;
	localparam int FWD_HALF_PERIOD_DEF = 2;

	// pin levels and reset values
	localparam logic CASCADE_IDLE_N = 1'b1;
	localparam logic CASCADE_ACTIVE_N = 1'b0;
	localparam logic PIN_FLOAT_N = 1'b1;
	localparam logic PIN_DRIVE_N = 1'b0;
	localparam logic OE_RESET_DRIVE_LEVEL = 1'b0;
	localparam logic LINK_HOLD_RESET = 1'b1;

	// power-up sequencing of the output-enable/reset pin
	typedef enum logic [1:0]
	{
		PS_HOLD = 2'b01,
		PS_RELEASED = 2'b10
	} pwr_state_e;

	// readout state on the configuration clock
	typedef enum logic [3:0]
	{
		LS_HELD = 4'b0001,
		LS_RUN = 4'b0010,
		LS_END = 4'b0100,
		LS_TC = 4'b1000
	} link_state_e;

endpackage
`default_nettype wire

/* File: config_prom_readout_control.sv */
// readout control of a configuration prom: address counter, output enables, cascade and power-up release
//
// Contract
// RL1 - chip enable high: standby, counter reset, cascade out high, other outputs float.
// RL2 - outside party keeps jtag pins undriven low and jtag clock static in standby.
// RL3 - serial variant running: increment below terminal count, drive data, cascade out high.
// RL4 - serial variant at terminal count: hold address, float data, cascade low, reduce current.
// RL5 - terminal count is highest array address; the address after it is zero.
// RL6 - parallel variant running: increment below terminal and end address, clock forwarded.
// RL7 - parallel at end address: hold, float data and clock, cascade high, reduce current.
// RL8 - parallel at terminal count: hold, float data and clock, cascade low, reduce current.
// RL9 - parallel busy high: freeze address and data, clock active, cascade high.
// RL10 - revision selection on: end address is last address of selected revision.
// RL11 - held reset loads selected bank start with revisions on, else address zero.
// RL12 - output-enable/reset low: held reset, data and clock float, cascade high, no standby.
// RL13 - device holds output-enable/reset low itself until power-on reset completes.
// RL14 - serial variant releases output-enable/reset at most one millisecond after power-on.
// RL15 - address and data advance on each rising configuration clock edge when allowed.
`timescale 1ns/100ps
`default_nettype none
module config_prom_readout_control
	import config_prom_pkg::*;
#(
	parameter int ARRAY_DEPTH = ARRAY_DEPTH_DEF,
	parameter int DATA_WIDTH = DATA_WIDTH_DEF,
	parameter int REV_COUNT = REV_COUNT_DEF,
	parameter bit PARALLEL_CAPABLE = 1'b0,
	parameter int OER_CYCLES = OER_RELEASE_CYCLES,
	parameter int FWD_HALF_PERIOD = FWD_HALF_PERIOD_DEF,
	localparam int ADDR_W = $clog2(ARRAY_DEPTH),
	localparam int REV_W = (REV_COUNT > 1) ? $clog2(REV_COUNT) : 1
) (
	// system side
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	// configuration clock from the link
	input wire logic i_cfg_clk,
	// control pins
	input wire logic i_chip_enable_n,
	input wire logic i_oe_reset,
	output logic o_oe_reset_out,
	output logic o_oe_reset_oe_n,
	input wire logic i_busy,
	input wire logic i_revision_enable,
	input wire logic [REV_W-1:0] i_revision_select,
	// array read port, same domain as the configuration clock
	output logic [ADDR_W-1:0] o_array_addr,
	input wire logic [DATA_WIDTH-1:0] i_array_data,
	// configuration data towards the target
	output logic [DATA_WIDTH-1:0] o_data,
	output logic o_data_oe_n,
	// forwarded clock and cascade
	output logic o_forwarded_config_clock,
	output logic o_forwarded_config_clock_oe_n,
	output logic o_cascade_enable_out_n,
	// supply current state
	output logic o_standby,
	output logic o_reduced_current
);

	localparam int BANK_W = ADDR_W - REV_W;
	localparam int OER_W = $clog2(OER_CYCLES + 1);
	localparam int FWD_W = $clog2(FWD_HALF_PERIOD + 1);
	localparam logic [ADDR_W-1:0] TERMINAL_COUNT = ADDR_W'(ARRAY_DEPTH - 1);
	localparam logic [ADDR_W-1:0] ADDR_ZERO = '0;
	localparam logic [OER_W-1:0] OER_LAST = OER_W'(OER_CYCLES);
	localparam logic [FWD_W-1:0] FWD_LAST = FWD_W'(FWD_HALF_PERIOD - 1);

	// ------------------------------------------------------------
	// system clock domain
	// ------------------------------------------------------------

	pwr_state_e pwr_state;
	pwr_state_e next_pwr_state;
	logic [OER_W-1:0] oer_count;
	logic [OER_W-1:0] next_oer_count;

	logic [3:0] sys_sync_in;
	logic [3:0] sys_sync_out;
	logic chip_enable_n_s;
	logic oe_reset_s;
	logic at_tc_s;
	logic at_end_s;
	logic at_tc_l;
	logic at_end_l;

	logic link_hold;
	logic held;
	logic stopped;
	logic driving;
	logic fwd_active;
	logic [FWD_W-1:0] fwd_count;
	logic fwd_wrap;

	// pins and link status pass two flops before use
	assign sys_sync_in = {at_end_l, at_tc_l, i_oe_reset, i_chip_enable_n};
	sync_2ff #(
		.WIDTH(4)
	) u_sys_sync (
		.i_clk(i_mclk),
		.i_d(sys_sync_in),
		.o_q(sys_sync_out)
	);
	assign chip_enable_n_s = sys_sync_out[0];
	assign oe_reset_s = sys_sync_out[1];
	assign at_tc_s = sys_sync_out[2];
	assign at_end_s = sys_sync_out[3];

	// power-up release: hold the pin low, then let it go after the delay
	always_comb
	begin
		next_pwr_state = pwr_state;
		next_oer_count = oer_count;
		unique case (pwr_state)
			PS_HOLD:
			begin
				if (oer_count == OER_LAST) // RL14
				begin
					next_pwr_state = PS_RELEASED;
				end
				else
				begin
					next_oer_count = oer_count + OER_W'(1);
				end
			end
			PS_RELEASED:
			begin
				next_pwr_state = PS_RELEASED;
			end
		endcase
	end

	// power-on reset is the system reset; the pin stays low throughout it
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			pwr_state <= PS_HOLD;
			oer_count <= '0;
		end
		else
		begin
			pwr_state <= next_pwr_state;
			oer_count <= next_oer_count;
		end
	end

	// open-drain pull-down; the level is fixed, only the enable moves
	assign o_oe_reset_out = OE_RESET_DRIVE_LEVEL; // RL13
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			o_oe_reset_oe_n <= PIN_DRIVE_N;
		end
		else
		begin
			o_oe_reset_oe_n <= (next_pwr_state == PS_HOLD) ? PIN_DRIVE_N : PIN_FLOAT_N; // RL13
		end
	end

	// held reset covers standby, a low pin from outside and our own power-up hold
	assign held = chip_enable_n_s | ~oe_reset_s | (pwr_state != PS_RELEASED); // RL1 RL12
	assign stopped = at_tc_s | (PARALLEL_CAPABLE & at_end_s); // RL4 RL7 RL8
	assign driving = ~held & ~stopped; // RL3 RL6
	// busy does not float the clock, only a stop or a reset does
	assign fwd_active = PARALLEL_CAPABLE & driving; // RL6 RL9

	// hold level handed to the link side, registered so the crossing sees one flop
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			link_hold <= LINK_HOLD_RESET;
		end
		else
		begin
			link_hold <= held; // RL1 RL12
		end
	end

	// pin enables and current state, all registered
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			o_data_oe_n <= PIN_FLOAT_N;
			o_forwarded_config_clock_oe_n <= PIN_FLOAT_N;
			o_cascade_enable_out_n <= CASCADE_IDLE_N;
			o_standby <= 1'b0;
			o_reduced_current <= 1'b0;
		end
		else
		begin
			o_data_oe_n <= driving ? PIN_DRIVE_N : PIN_FLOAT_N; // RL3 RL4 RL7 RL8
			o_forwarded_config_clock_oe_n <= fwd_active ? PIN_DRIVE_N : PIN_FLOAT_N; // RL7 RL8 RL12
			o_cascade_enable_out_n <= (!held && at_tc_s) ? CASCADE_ACTIVE_N : CASCADE_IDLE_N; // RL4 RL8 RL1
			o_standby <= chip_enable_n_s; // RL1
			o_reduced_current <= ~held & stopped; // RL4 RL7 RL8
		end
	end

	// forwarded clock divider; runs free so the target sees a steady rate
	assign fwd_wrap = (fwd_count == FWD_LAST);
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			fwd_count <= '0;
			o_forwarded_config_clock <= 1'b0;
		end
		else if (fwd_wrap)
		begin
			fwd_count <= '0;
			o_forwarded_config_clock <= ~o_forwarded_config_clock;
		end
		else
		begin
			fwd_count <= fwd_count + FWD_W'(1);
		end
	end

	// ------------------------------------------------------------
	// configuration clock domain
	// ------------------------------------------------------------

	link_state_e link_state;
	link_state_e next_link_state;
	logic [ADDR_W-1:0] addr;
	logic [ADDR_W-1:0] next_addr;
	logic [DATA_WIDTH-1:0] next_data;

	logic [REV_W+2:0] link_sync_in;
	logic [REV_W+2:0] link_sync_out;
	logic hold_l;
	logic busy_l;
	logic rev_enable_l;
	logic [REV_W-1:0] rev_select_l;

	logic use_revision;
	logic stall;
	logic at_tc_now;
	logic at_end_now;
	logic [ADDR_W-1:0] bank_start;
	logic [ADDR_W-1:0] bank_end;
	logic [ADDR_W-1:0] start_addr;
	logic [ADDR_W-1:0] addr_plus_one;

	// revision select is a strap that settles before release, so per-bit sync is enough
	assign link_sync_in = {i_revision_select, i_revision_enable, i_busy, link_hold};
	sync_2ff #(
		.WIDTH(REV_W + 3)
	) u_link_sync (
		.i_clk(i_cfg_clk),
		.i_d(link_sync_in),
		.o_q(link_sync_out)
	);
	assign hold_l = link_sync_out[0];
	assign busy_l = link_sync_out[1];
	assign rev_enable_l = link_sync_out[2];
	assign rev_select_l = link_sync_out[REV_W+2:3];

	// revision banks split the array evenly by the top address bits
	assign use_revision = PARALLEL_CAPABLE & rev_enable_l & (REV_COUNT > 1);
	assign bank_start = {rev_select_l, {BANK_W{1'b0}}}; // RL11
	assign bank_end = {rev_select_l, {BANK_W{1'b1}}}; // RL10
	assign start_addr = use_revision ? bank_start : ADDR_ZERO; // RL11

	// the address past terminal count wraps to zero
	assign addr_plus_one = (addr == TERMINAL_COUNT) ? ADDR_ZERO : addr + ADDR_W'(1); // RL5

	// stop and stall decisions
	assign at_tc_now = (addr == TERMINAL_COUNT); // RL4 RL8
	assign at_end_now = use_revision & (addr == bank_end); // RL7 RL10
	assign stall = PARALLEL_CAPABLE & busy_l; // RL9
	assign o_array_addr = addr;

	// readout sequencing; a hold always wins, busy only pauses a running readout
	always_comb
	begin
		next_link_state = link_state;
		next_addr = addr;
		next_data = o_data;
		if (hold_l)
		begin
			next_link_state = LS_HELD;
			next_addr = start_addr; // RL1 RL11 RL12
		end
		else
		begin
			unique case (link_state)
				LS_HELD, LS_RUN:
				begin
					if (stall)
					begin
						next_link_state = link_state; // RL9
					end
					else if (at_tc_now)
					begin
						next_link_state = LS_TC; // RL4 RL8
					end
					else if (at_end_now)
					begin
						next_link_state = LS_END; // RL7
					end
					else
					begin
						next_link_state = LS_RUN;
						next_data = i_array_data; // RL15
						next_addr = addr_plus_one; // RL3 RL6 RL15
					end
				end
				LS_END:
				begin
					next_link_state = LS_END; // RL7
				end
				LS_TC:
				begin
					next_link_state = LS_TC; // RL4 RL8
				end
			endcase
		end
	end

	// link-side reset is the synchronised hold, since power-on reset lives on the other clock
	always_ff @(posedge i_cfg_clk)
	begin
		link_state <= next_link_state;
		addr <= next_addr;
		o_data <= next_data;
	end

	// stop flags are levels, crossed back through two flops
	always_ff @(posedge i_cfg_clk)
	begin
		if (hold_l)
		begin
			at_tc_l <= 1'b0;
			at_end_l <= 1'b0;
		end
		else
		begin
			at_tc_l <= (next_link_state == LS_TC);
			at_end_l <= (next_link_state == LS_END);
		end
	end

endmodule
`default_nettype wire

/* File: readout_sva.sv */
// assertion checker for the prom readout control
`timescale 1ns/100ps
`default_nettype none
module readout_sva #(
	parameter int ADDR_W = 4,
	parameter int DATA_WIDTH = 1
) (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_cfg_clk,
	input wire logic i_chip_enable_n,
	input wire logic i_oe_reset,
	input wire logic i_busy,
	input wire logic [ADDR_W-1:0] o_array_addr,
	input wire logic [DATA_WIDTH-1:0] o_data,
	input wire logic o_data_oe_n,
	input wire logic o_forwarded_config_clock_oe_n,
	input wire logic o_cascade_enable_out_n,
	input wire logic o_standby,
	input wire logic o_reduced_current,
	input wire logic o_oe_reset_oe_n
);
	// pin levels pass two sync flops, so allow five edges of settled input
	standby_entry_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst) i_chip_enable_n [*5] |->
		o_standby && o_data_oe_n && o_cascade_enable_out_n && o_forwarded_config_clock_oe_n) else $error("standby outputs");
	held_reset_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst) (!i_oe_reset && !i_chip_enable_n) [*5] |->
		o_data_oe_n && o_cascade_enable_out_n && !o_standby) else $error("held reset outputs");
	por_hold_a: assert property (@(posedge i_mclk) $fell(i_sys_rst) |-> !o_oe_reset_oe_n [*8])
		else $error("reset wire released early");
	por_release_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst) $fell(i_sys_rst) |-> ##[1:100] o_oe_reset_oe_n)
		else $error("reset wire never released");
	cascade_stop_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst) $fell(o_cascade_enable_out_n) |->
		##[0:2] (o_reduced_current && o_data_oe_n)) else $error("cascade without stop");
	end_stop_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst) $rose(o_reduced_current) |->
		##[0:2] (o_data_oe_n && o_forwarded_config_clock_oe_n)) else $error("stop without float");
	data_active_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst) !o_data_oe_n |-> !o_standby)
		else $error("data driven in standby");
	busy_freeze_a: assert property (@(posedge i_cfg_clk) disable iff (i_sys_rst) i_busy [*4] |=>
		$stable(o_array_addr) && $stable(o_data)) else $error("moved while busy");
endmodule
bind config_prom_readout_control readout_sva #(.ADDR_W(ADDR_W), .DATA_WIDTH(DATA_WIDTH)) chk (.i_mclk, .i_sys_rst,
	.i_cfg_clk, .i_chip_enable_n, .i_oe_reset, .i_busy, .o_array_addr, .o_data, .o_data_oe_n,
	.o_forwarded_config_clock_oe_n, .o_cascade_enable_out_n, .o_standby, .o_reduced_current, .o_oe_reset_oe_n);
`default_nettype wire

/* File: sync_2ff.sv */
// two flip-flop level synchroniser for pins and cross-domain levels
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
	parameter int WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic [WIDTH-1:0] i_d,
	output logic [WIDTH-1:0] o_q
);

	logic [WIDTH-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge i_clk)
	begin
		meta <= i_d;
		o_q <= meta;
	end

endmodule
`default_nettype wire

/* File: target_port_model.sv */
// model of the target configuration port: frame clock and busy stall
`timescale 1ns/100ps
`default_nettype none
module target_port_model (
	input wire logic i_frame,
	input wire logic i_stall,
	output logic o_cfg_clk,
	output logic o_busy
);
	// 12 ns clock, resting low between frames, odd phase to the system clock
	// the far side's test-port pins are not modelled; they stay idle like this clock
	initial
	begin
		o_cfg_clk = 1'b0;
		o_busy = 1'b0;
		#3.7;
		forever
			#6 o_cfg_clk = i_frame ? ~o_cfg_clk : 1'b0;
	end
	// busy moves just after a rising edge, never on it
	always @(posedge o_cfg_clk)
		o_busy <= i_stall;
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the prom readout control
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import config_prom_pkg::*;
	localparam int DEPTH = 16;
	logic i_mclk, i_sys_rst, i_cfg_clk, i_chip_enable_n, i_oe_reset, i_busy, i_revision_enable, frame, stall, hold_n;
	logic [0:0] i_revision_select;
	logic [3:0] o_array_addr, last, held;
	logic [7:0] i_array_data, o_data, mem [DEPTH];
	logic o_oe_reset_out, o_oe_reset_oe_n, o_data_oe_n, o_forwarded_config_clock_oe_n, o_cascade_enable_out_n;
	logic o_standby, o_reduced_current, running;
	logic [3:0] ser_addr, ser_last;
	logic [7:0] ser_data, ser_array_data;
	logic ser_oe_out, ser_oe_n, ser_data_oe_n, ser_clk_oe_n, ser_cascade_n, ser_standby, ser_reduced;
	logic fwd_clk, fwd_seen;
	int num_errors, num_checks, seed, cycles;
	// open-drain reset wire with pull-up, pulled by prom or bench
	assign i_oe_reset = (o_oe_reset_oe_n | o_oe_reset_out) & (ser_oe_n | ser_oe_out) & hold_n;
	assign i_array_data = mem[o_array_addr];
	assign ser_array_data = mem[ser_addr];
	config_prom_readout_control #(.ARRAY_DEPTH(DEPTH), .DATA_WIDTH(8), .REV_COUNT(2), .PARALLEL_CAPABLE(1'b1),
		.OER_CYCLES(20)) dut (.i_mclk, .i_sys_rst, .i_cfg_clk, .i_chip_enable_n, .i_oe_reset, .o_oe_reset_out,
		.o_oe_reset_oe_n, .i_busy, .i_revision_enable, .i_revision_select, .o_array_addr, .i_array_data, .o_data,
		.o_data_oe_n, .o_forwarded_config_clock(fwd_clk), .o_forwarded_config_clock_oe_n, .o_cascade_enable_out_n,
		.o_standby, .o_reduced_current);
	target_port_model partner (.i_frame(frame), .i_stall(stall), .o_cfg_clk(i_cfg_clk), .o_busy(i_busy));
	// serial-only twin on the same pins; it ignores busy and revisions
	config_prom_readout_control #(.ARRAY_DEPTH(DEPTH), .DATA_WIDTH(8), .REV_COUNT(2), .PARALLEL_CAPABLE(1'b0),
		.OER_CYCLES(20)) dut_serial (.i_mclk, .i_sys_rst, .i_cfg_clk, .i_chip_enable_n, .i_oe_reset,
		.o_oe_reset_out(ser_oe_out), .o_oe_reset_oe_n(ser_oe_n), .i_busy(1'b0), .i_revision_enable(1'b0),
		.i_revision_select(1'b0), .o_array_addr(ser_addr), .i_array_data(ser_array_data), .o_data(ser_data),
		.o_data_oe_n(ser_data_oe_n), .o_forwarded_config_clock(), .o_forwarded_config_clock_oe_n(ser_clk_oe_n),
		.o_cascade_enable_out_n(ser_cascade_n), .o_standby(ser_standby), .o_reduced_current(ser_reduced));
	initial
	begin
		i_mclk = 1'b0;
		forever
			#2.5 i_mclk = ~i_mclk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	// bank start and stop address for each pass
	function automatic logic [3:0] start_of(input int pass);
		return (pass == 2) ? 4'h8 : 4'h0;
	endfunction
	function automatic logic [3:0] end_of(input int pass);
		return (pass == 1) ? 4'h7 : 4'hf;
	endfunction
	// hang guard: the whole run needs far fewer cycles
	always @(posedge i_mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			num_errors++;
			wrap_up;
		end
	end
	// every advance presents the word of the address just left
	always @(posedge i_cfg_clk)
	begin
		#1;
		if (running && o_array_addr !== last)
		begin
			check(o_array_addr, last + 4'h1);
			check(o_data, mem[last]);
		end
		if (running && ser_addr !== ser_last)
		begin
			check(ser_addr, ser_last + 4'h1);
			check(ser_data, mem[ser_last]);
			check({ser_data_oe_n, ser_cascade_n}, 2'b01);
		end
		last = o_array_addr;
		ser_last = ser_addr;
	end
	initial
	begin
		seed = 44;
		num_errors = 0;
		num_checks = 0;
		cycles = 0;
		running = 1'b0;
		i_sys_rst = 1'b1;
		i_chip_enable_n = 1'b1;
		hold_n = 1'b1;
		i_revision_enable = 1'b0;
		i_revision_select = 1'b0;
		frame = 1'b0;
		stall = 1'b0;
		foreach (mem[i])
			mem[i] = 8'($random(seed));
		cyc(6);
		i_sys_rst <= 1'b0;
		cyc(2);
		check({o_oe_reset_oe_n, ser_oe_n, o_oe_reset_out, ser_oe_out}, 4'h0);
		cyc(30);
		check({o_oe_reset_oe_n, ser_oe_n}, 2'b11);
		check({o_standby, o_cascade_enable_out_n, o_data_oe_n}, 3'b111);
		// whole array without revisions, then bank 0 and bank 1
		for (int pass = 0; pass < 3; pass++)
		begin
			i_revision_enable <= (pass != 0);
			i_revision_select <= 1'(pass == 2);
			hold_n <= 1'b0;
			i_chip_enable_n <= 1'b0;
			frame <= 1'b1;
			cyc(12);
			check({o_standby, o_cascade_enable_out_n, o_data_oe_n,
				ser_standby, ser_cascade_n, ser_data_oe_n}, 6'b011011);
			check(o_array_addr, start_of(pass));
			check(ser_addr, 4'h0);
			// the forwarded clock flips once in any two system clocks
			fwd_seen = fwd_clk;
			cyc(2);
			check(fwd_clk, !fwd_seen);
			// advances are only watched once the held address has settled
			hold_n <= 1'b1;
			running <= 1'b1;
			if (pass == 0)
			begin
				repeat (2 + $unsigned($random(seed)) % 4) @(posedge i_cfg_clk);
				stall <= 1'b1;
				repeat (4) @(posedge i_cfg_clk);
				held = o_array_addr;
				repeat (6) @(posedge i_cfg_clk);
				check(o_array_addr, held);
				check({o_data_oe_n, o_forwarded_config_clock_oe_n}, 2'b00);
				stall <= 1'b0;
			end
			for (int i = 0; i < 400 && (o_reduced_current !== 1'b1 || ser_reduced !== 1'b1); i++)
				cyc(1);
			cyc(4);
			running <= 1'b0;
			check(o_array_addr, end_of(pass));
			check({o_cascade_enable_out_n, o_data_oe_n, o_forwarded_config_clock_oe_n, o_reduced_current},
				{1'(pass == 1), 3'b111});
			check({ser_cascade_n, ser_data_oe_n, ser_clk_oe_n, ser_reduced, ser_addr}, 8'h7f);
			i_chip_enable_n <= 1'b1;
			cyc(12);
			check({o_standby, o_cascade_enable_out_n, o_data_oe_n, o_reduced_current,
				ser_standby, ser_cascade_n, ser_data_oe_n, ser_reduced}, 8'hee);
			check(o_array_addr, start_of(pass));
			check(ser_addr, 4'h0);
			frame <= 1'b0;
			cyc(4);
		end
		wrap_up;
	end
endmodule
`default_nettype wire
